// file: src/crt_pkg.sv
// Package with register map, field positions and carrier types of the capture/reload timer.
package crt_pkg;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h00_C8;
  localparam logic [7:0] TIMER_MODE_CONTROL_ADDR = 8'h00_C9;
  localparam logic [7:0] CAPTURE_RELOAD_LOW_ADDR = 8'h00_CA;
  localparam logic [7:0] CAPTURE_RELOAD_HIGH_ADDR = 8'h00_CB;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h00_CC;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h00_CD;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00_00;
  localparam logic [7:0] TIMER_MODE_CONTROL_RESET = 8'h00_00;
  localparam logic [7:0] BYTE_RESET = 8'h00_00;
  // Bit positions in timer_control.
  localparam int CTL_OVERFLOW_FLAG = 7;
  localparam int CTL_EXTERNAL_EVENT_FLAG = 6;
  localparam int CTL_RX_BAUD_SELECT = 5;
  localparam int CTL_TX_BAUD_SELECT = 4;
  localparam int CTL_TRIGGER_ENABLE = 3;
  localparam int CTL_RUN_CONTROL = 2;
  localparam int CTL_TIMER_COUNTER_SELECT = 1;
  localparam int CTL_CAPTURE_RELOAD_SELECT = 0;
  // Bit positions in timer_mode_control.
  localparam int MOD_AUTO_CLEAR_EXT_IRQ5 = 7;
  localparam int MOD_AUTO_CLEAR_EXT_IRQ2 = 4;
  localparam int MOD_CAPTURE_RESET_ENABLE = 2;
  localparam int MOD_CLOCK_OUT_ENABLE = 1;
  localparam int MOD_DOWN_COUNT_ENABLE = 0;
  // Baud generator mode advances once every this many clocks.
  localparam int BAUD_TICK_CYCLES = 2;
  localparam int SLOW_TICK_CYCLES_DEFAULT = 12;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] countPin;
    logic [2:0] triggerPin;
    logic countSync;
    logic trigSync;
    logic [3:0] divCount;
    logic baudPhase;
    logic [7:0] control;
    logic [7:0] modeControl;
    logic [15:0] reload;
    logic [15:0] count;
    logic [7:0] rdata;
    logic rxBaudTick;
    logic txBaudTick;
    logic clockOut;
    logic timerIrq;
  } crt_state_t;
endpackage : crt_pkg

// file: src/capture_reload_timer.sv
// Sixteen-bit capture/reload timer with baud generator and clock-out.
// Operation
// (R01) Overflow flag sets on rollover, or on count equal to reload when counting down.
// (R02) Hardware sets overflow flag only if both baud selects are 0; software writes it.
// (R03) External event flag sets on trigger falling edge or overflow per mode bits.
// (R04) External event flag set by software or edge raises timer interrupt if enabled.
// (R05) Receive baud select picks this timer for receive time base and forces baud mode.
// (R06) Transmit baud select picks this timer for transmit time base and forces baud mode.
// (R07) Trigger pin ignored unless trigger enabled and timer not generating baud clocks; its level still sets down-count direction with trigger disabled.
// (R08) Run control starts and stops counting; stopping keeps the count.
// (R09) Timer select 0 counts internal ticks at selected rate; 1 counts pin falling edges.
// (R10) Baud generator mode advances the count once every 2 clocks.
// (R11) Any baud select forces auto-reload on every overflow, ignoring capture select.
// (R12) Capture select 0 reloads on overflow and on enabled trigger falling edge; the code skips the trigger reload while down-count enable is set.
// (R13) Capture select 1 copies the count into capture registers on enabled trigger edge; the code skips the capture while down-count enable is set.
// (R14) Capture-reset enable clears the counter after a capture.
// (R15) Clock-out enable switches the clock output on and off.
// (R16) Down-count enable with trigger level sets direction in auto-reload mode.
// (R17) Low capture byte takes low count, high capture byte takes high count.
// (R18) Capture registers form the 16-bit reload value in auto-reload mode.
// (R19) Auto-clear bits for external interrupts 2 to 5 clear flags on service entry.
// (R20) Counter is 16 bits, low byte 7:0, high byte 15:8; rollover from all ones overflows.
// (R21) With down-count on, count up while trigger high and down while low.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module capture_reload_timer #(
  parameter int SLOW_TICK_CYCLES = crt_pkg::SLOW_TICK_CYCLES_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire crt_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic countInputPin,
  input wire logic triggerPin,
  input wire logic tickRateSelect,
  input wire logic timerIrqEnable,
  output logic timerIrq,
  output logic rxBaudTick,
  output logic txBaudTick,
  output logic clockOut,
  output logic clockOutEnable,
  output logic [3:0] autoClearExtIrq
);
  import crt_pkg::*;

  crt_state_t state_q;
  crt_state_t state_d;

  logic baudMode;
  logic countFall;
  logic trigFall;
  logic trigLevel;
  logic slowTick;
  logic advance;
  logic downMode;
  logic atRollover;
  logic atReloadDown;
  logic overflow;
  logic trigAction;
  logic setOverflowFlag;
  logic setEventFlag;
  logic runOn;
  logic [15:0] nextCount;

  always_comb begin
    state_d = state_q;
    // Only the second and third stages are compared, so the first never feeds logic.
    state_d.countPin = {state_q.countPin[1:0], countInputPin};
    state_d.triggerPin = {state_q.triggerPin[1:0], triggerPin};
    // A level is taken only when two stages agree, so a one-cycle glitch never counts.
    if (state_q.countPin[2] == state_q.countPin[1]) begin
      state_d.countSync = state_q.countPin[2];
    end
    if (state_q.triggerPin[2] == state_q.triggerPin[1]) begin
      state_d.trigSync = state_q.triggerPin[2];
    end
    countFall = state_q.countSync & ~state_d.countSync;
    trigFall = state_q.trigSync & ~state_d.trigSync;
    trigLevel = state_q.trigSync;
    baudMode = state_q.control[CTL_RX_BAUD_SELECT] | state_q.control[CTL_TX_BAUD_SELECT]; // R05 R06
    runOn = state_q.control[CTL_RUN_CONTROL];
    slowTick = 1'b0;
    if (state_q.divCount == 4'(SLOW_TICK_CYCLES - 1)) begin
      state_d.divCount = 4'h0;
      slowTick = 1'b1;
    end else begin
      state_d.divCount = state_q.divCount + 4'h1;
    end
    state_d.baudPhase = ~state_q.baudPhase;
    if (!runOn) begin
      advance = 1'b0; // R08
    end else if (baudMode) begin
      advance = state_q.baudPhase; // R10
    end else if (state_q.control[CTL_TIMER_COUNTER_SELECT]) begin
      advance = countFall; // R09
    end else begin
      advance = tickRateSelect | slowTick; // R09
    end
    // Down counting is only meaningful in plain auto-reload, not with baud clocks.
    downMode = state_q.modeControl[MOD_DOWN_COUNT_ENABLE] & ~baudMode
      & ~state_q.control[CTL_CAPTURE_RELOAD_SELECT] & ~trigLevel; // R16 R21
    atRollover = state_q.count == 16'hFFFF; // R20
    atReloadDown = state_q.count == state_q.reload;
    overflow = advance & (downMode ? atReloadDown : atRollover); // R01
    if (downMode) begin
      nextCount = atReloadDown ? 16'hFFFF : state_q.count - 16'h0001;
    end else if (overflow
        && (baudMode || !state_q.control[CTL_CAPTURE_RELOAD_SELECT])) begin
      nextCount = state_q.reload; // R11 R12 R18
    end else begin
      nextCount = state_q.count + 16'h0001; // R20
    end
    if (advance) begin
      state_d.count = nextCount;
    end
    trigAction = trigFall & state_q.control[CTL_TRIGGER_ENABLE] & ~baudMode; // R07
    // Trigger edges only capture or reload when down counting is disabled.
    if (trigAction && !state_q.modeControl[MOD_DOWN_COUNT_ENABLE]) begin
      if (state_q.control[CTL_CAPTURE_RELOAD_SELECT]) begin
        state_d.reload = state_q.count; // R13 R17
        if (state_q.modeControl[MOD_CAPTURE_RESET_ENABLE]) begin
          state_d.count = 16'h0000; // R14
        end
      end else begin
        state_d.count = state_q.reload; // R12
      end
    end
    setOverflowFlag = overflow & ~baudMode; // R02
    setEventFlag = (trigAction & ~state_q.modeControl[MOD_DOWN_COUNT_ENABLE])
      | (overflow & downMode); // R03
    state_d.rxBaudTick = overflow & state_q.control[CTL_RX_BAUD_SELECT]; // R05
    state_d.txBaudTick = overflow & state_q.control[CTL_TX_BAUD_SELECT]; // R06
    if (overflow && state_q.modeControl[MOD_CLOCK_OUT_ENABLE]) begin
      state_d.clockOut = ~state_q.clockOut; // R15
    end else if (!state_q.modeControl[MOD_CLOCK_OUT_ENABLE]) begin
      state_d.clockOut = 1'b0; // R15
    end
    if (regReq.write) begin
      unique case (regReq.addr)
        TIMER_CONTROL_ADDR: state_d.control = regReq.wdata; // R02
        TIMER_MODE_CONTROL_ADDR: state_d.modeControl = regReq.wdata; // R19
        CAPTURE_RELOAD_LOW_ADDR: state_d.reload[7:0] = regReq.wdata;
        CAPTURE_RELOAD_HIGH_ADDR: state_d.reload[15:8] = regReq.wdata;
        COUNT_LOW_ADDR: state_d.count[7:0] = regReq.wdata;
        COUNT_HIGH_ADDR: state_d.count[15:8] = regReq.wdata;
        default: ;
      endcase
    end
    // A hardware event beats a software clear in the same cycle.
    if (setOverflowFlag) begin
      state_d.control[CTL_OVERFLOW_FLAG] = 1'b1; // R01 R02
    end
    if (setEventFlag) begin
      state_d.control[CTL_EXTERNAL_EVENT_FLAG] = 1'b1; // R03
    end
    // Registered, so the request is a level that stands until software clears both flags or timerIrqEnable goes low.
    state_d.timerIrq = timerIrqEnable
      & (state_d.control[CTL_OVERFLOW_FLAG] | state_d.control[CTL_EXTERNAL_EVENT_FLAG]); // R04
    state_d.rdata = 8'h00_00;
    if (regReq.read) begin
      unique case (regReq.addr)
        TIMER_CONTROL_ADDR: state_d.rdata = state_q.control;
        TIMER_MODE_CONTROL_ADDR: state_d.rdata = state_q.modeControl;
        CAPTURE_RELOAD_LOW_ADDR: state_d.rdata = state_q.reload[7:0];
        CAPTURE_RELOAD_HIGH_ADDR: state_d.rdata = state_q.reload[15:8];
        COUNT_LOW_ADDR: state_d.rdata = state_q.count[7:0];
        COUNT_HIGH_ADDR: state_d.rdata = state_q.count[15:8];
        default: state_d.rdata = 8'h00_00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdata = state_q.rdata;
  assign timerIrq = state_q.timerIrq; // R04
  assign rxBaudTick = state_q.rxBaudTick;
  assign txBaudTick = state_q.txBaudTick;
  assign clockOut = state_q.clockOut;
  assign clockOutEnable = state_q.modeControl[MOD_CLOCK_OUT_ENABLE]; // R15
  assign autoClearExtIrq = state_q.modeControl[MOD_AUTO_CLEAR_EXT_IRQ5:MOD_AUTO_CLEAR_EXT_IRQ2]; // R19
endmodule : capture_reload_timer

// file: sim/crt_partner.sv
// Pin driver and serial baud-tick monitor beside the timer.
`timescale 1ns/1ps
module crt_partner (
  input wire logic clk_sys,
  input wire logic rxBaudTick,
  input wire logic txBaudTick,
  output logic triggerPin,
  output logic countInputPin,
  output int rxPeriod,
  output int txPeriod
);
  int gap = 0;
  int txGap = 0;
  initial begin
    triggerPin = 1'b1;
    countInputPin = 1'b1;
    rxPeriod = 0;
    txPeriod = 0;
  end
  // The trigger level steers the count direction, so it can be held for a whole test.
  task automatic hold_trigger(input bit lvl);
    @(posedge clk_sys);
    triggerPin <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask : hold_trigger
  // Lows last 4 clocks so the three-flop synchroniser never misses an edge.
  task automatic pulse(input bit trig);
    @(posedge clk_sys);
    if (trig) triggerPin <= 1'b0;
    else countInputPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    triggerPin <= 1'b1;
    countInputPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : pulse
  always @(posedge clk_sys) begin
    gap <= rxBaudTick ? 1 : gap + 1;
    if (rxBaudTick) rxPeriod <= gap;
    txGap <= txBaudTick ? 1 : txGap + 1;
    if (txBaudTick) txPeriod <= txGap;
  end
endmodule : crt_partner

// file: sim/capture_reload_timer_assertions.sv
// Port assertions and covers for the capture/reload timer.
`timescale 1ns/1ps
module crt_checker
  import crt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire crt_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic timerIrqEnable,
  input wire logic timerIrq,
  input wire logic rxBaudTick,
  input wire logic txBaudTick,
  input wire logic clockOut,
  input wire logic clockOutEnable,
  input wire logic [3:0] autoClearExtIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic modeWr;
  logic mapped;
  assign modeWr = regReq.write && regReq.addr == TIMER_MODE_CONTROL_ADDR;
  assign mapped = regReq.addr >= TIMER_CONTROL_ADDR && regReq.addr <= COUNT_HIGH_ADDR;
  rdata_idle_a: assert property (!regReq.read |=> regRdata == 8'h00_00)
    else $error("read data not zero");
  unmapped_read_a: assert property (regReq.read && !mapped |=> regRdata == 8'h00_00)
    else $error("unmapped read not zero");
  irq_enable_a: assert property (timerIrq |-> $past(timerIrqEnable))
    else $error("interrupt without enable");
  irq_mask_a: assert property (!timerIrqEnable |=> !timerIrq)
    else $error("interrupt not masked");
  clkout_off_a: assert property (!clockOutEnable [*2] |-> !clockOut)
    else $error("clock out while disabled");
  oe_write_a: assert property (modeWr |=> clockOutEnable == $past(regReq.wdata[1]))
    else $error("clock out enable not written");
  hc_write_a: assert property (modeWr |=> autoClearExtIrq == $past(regReq.wdata[7:4]))
    else $error("auto clear bits not written");
  hc_hold_a: assert property (!modeWr |=> $stable(autoClearExtIrq))
    else $error("auto clear bits changed");
  rx_pulse_a: assert property (rxBaudTick |=> !rxBaudTick)
    else $error("receive tick too long");
  tx_pulse_a: assert property (txBaudTick |=> !txBaudTick)
    else $error("transmit tick too long");
  cover property (rxBaudTick ##1 !rxBaudTick);
  cover property (timerIrq);
  cover property (regReq.read ##1 regRdata != 8'h00_00);
endmodule : crt_checker
bind capture_reload_timer crt_checker crt_checker_i (.clk_sys(clk_sys), .reset(reset),
  .regReq(regReq), .regRdata(regRdata), .timerIrqEnable(timerIrqEnable),
  .timerIrq(timerIrq), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick),
  .clockOut(clockOut), .clockOutEnable(clockOutEnable), .autoClearExtIrq(autoClearExtIrq));

// file: sim/test_capture_reload_timer.sv
// Self-checking bench for the capture/reload timer.
`timescale 1ns/1ps
module test_capture_reload_timer;
  import crt_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_t regReq = '0;
  logic rateSel = 1'b1;
  logic irqEn = 1'b1;
  logic [7:0] regRdata;
  logic timerIrq, rxBaudTick, txBaudTick, clockOut, clockOutEnable, triggerPin, countPin;
  logic [3:0] autoClear;
  logic [15:0] v;
  int rxPeriod;
  int txPeriod;
  int n;
  int error_cnt = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  capture_reload_timer #(.SLOW_TICK_CYCLES(2)) capture_reload_timer_i (.clk_sys(clk_sys),
    .reset(reset), .regReq(regReq), .regRdata(regRdata), .countInputPin(countPin),
    .triggerPin(triggerPin), .tickRateSelect(rateSel), .timerIrqEnable(irqEn),
    .timerIrq(timerIrq), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick),
    .clockOut(clockOut), .clockOutEnable(clockOutEnable), .autoClearExtIrq(autoClear));
  crt_partner crt_partner_i (.clk_sys(clk_sys), .rxBaudTick(rxBaudTick),
    .txBaudTick(txBaudTick), .triggerPin(triggerPin), .countInputPin(countPin),
    .rxPeriod(rxPeriod), .txPeriod(txPeriod));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Every overflow reloads, so a period is the distance to rollover at two clocks a step.
  function automatic logic [15:0] baud_period(input logic [15:0] reload);
    return 16'((17'h1_0000 - 17'(reload)) * BAUD_TICK_CYCLES);
  endfunction : baud_period
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk_sys);
    regReq.write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    regReq <= '{addr: a, wdata: 8'h00_00, write: 1'b0, read: 1'b1};
    @(posedge clk_sys);
    regReq.read <= 1'b0;
    #1 chk(what, {8'h00_00, regRdata}, {8'h00_00, exp});
  endtask : rd
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(3000 * 100);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(3491));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 8'h00_C7; a <= 8'h00_CE; a++) rd(a[7:0], 8'h00_00, "reset");
    for (int a = 8'h00_CA; a <= 8'h00_CD; a++) begin
      v = 16'($urandom);
      wr(a[7:0], v[7:0]);
      rd(a[7:0], v[7:0], "byte reg");
    end
    v = 16'($urandom);
    wr(TIMER_MODE_CONTROL_ADDR, v[7:0]);
    #1 chk("oe", {15'h0000, clockOutEnable}, {15'h0000, v[1]});
    chk("hc", {12'h000, autoClear}, {12'h000, v[7:4]});
    wr(TIMER_MODE_CONTROL_ADDR, 8'h02);
    $display("test registers done");
    wr(TIMER_CONTROL_ADDR, 8'h00_C0);
    #1 chk("irq", {15'h0000, timerIrq}, 16'h0001);
    @(posedge clk_sys) irqEn <= 1'b0;
    @(posedge clk_sys) irqEn <= 1'b1;
    #1 chk("irq off", {15'h0000, timerIrq}, 16'h0000);
    rd(TIMER_CONTROL_ADDR, 8'h00_C0, "sw flags");
    $display("test flags done");
    v = {8'($urandom), 8'h00_10};
    wr(CAPTURE_RELOAD_LOW_ADDR, v[7:0]);
    wr(CAPTURE_RELOAD_HIGH_ADDR, v[15:8]);
    wr(COUNT_LOW_ADDR, 8'h00_FE);
    wr(COUNT_HIGH_ADDR, 8'h00_FF);
    @(posedge clk_sys) rateSel <= 1'($urandom);
    wr(TIMER_CONTROL_ADDR, 8'h00_04);
    repeat (20) @(posedge clk_sys);
    rd(TIMER_CONTROL_ADDR, 8'h00_84, "overflow");
    rd(COUNT_HIGH_ADDR, v[15:8], "reloaded");
    chk("clock out", {15'h0000, clockOut}, 16'h0001);
    wr(TIMER_CONTROL_ADDR, 8'h00_00);
    $display("test overflow done");
    crt_partner_i.hold_trigger(1'b0);
    @(posedge clk_sys) rateSel <= 1'b1;
    wr(CAPTURE_RELOAD_LOW_ADDR, 8'h04);
    wr(CAPTURE_RELOAD_HIGH_ADDR, 8'h00);
    wr(COUNT_LOW_ADDR, 8'h10);
    wr(COUNT_HIGH_ADDR, 8'h00);
    wr(TIMER_MODE_CONTROL_ADDR, 8'h01);
    wr(TIMER_CONTROL_ADDR, 8'h04);
    repeat (20) @(posedge clk_sys);
    rd(TIMER_CONTROL_ADDR, 8'hC4, "underflow flags");
    rd(COUNT_HIGH_ADDR, 8'hFF, "count down");
    wr(TIMER_CONTROL_ADDR, 8'h00);
    crt_partner_i.hold_trigger(1'b1);
    $display("test down count done");
    // Counted pin edges leave a known count, so the capture is exact.
    n = 1 + $urandom % 9;
    wr(TIMER_MODE_CONTROL_ADDR, 8'h00_04);
    wr(COUNT_LOW_ADDR, 8'h00_00);
    wr(COUNT_HIGH_ADDR, 8'h00_00);
    wr(TIMER_CONTROL_ADDR, 8'h00_0F);
    repeat (n) crt_partner_i.pulse(1'b0);
    crt_partner_i.pulse(1'b1);
    rd(CAPTURE_RELOAD_LOW_ADDR, n[7:0], "capture low");
    rd(CAPTURE_RELOAD_HIGH_ADDR, 8'h00_00, "capture high");
    rd(COUNT_LOW_ADDR, 8'h00_00, "capture reset");
    rd(TIMER_CONTROL_ADDR, 8'h00_4F, "event flag");
    chk("clock out off", {15'h0000, clockOut}, 16'h0000);
    wr(TIMER_CONTROL_ADDR, 8'h00_00);
    $display("test capture done");
    // The count is loaded too, or the first rollover would be far beyond the wait.
    v = {8'hFF, 8'($urandom) | 8'hE0};
    wr(CAPTURE_RELOAD_LOW_ADDR, v[7:0]);
    wr(CAPTURE_RELOAD_HIGH_ADDR, v[15:8]);
    wr(COUNT_LOW_ADDR, v[7:0]);
    wr(COUNT_HIGH_ADDR, v[15:8]);
    wr(TIMER_CONTROL_ADDR, 8'h27);
    repeat (160) @(posedge clk_sys);
    chk("baud period", 16'(rxPeriod), baud_period(v));
    chk("tx unused", 16'(txPeriod), 16'h0000);
    rd(TIMER_CONTROL_ADDR, 8'h27, "baud no flag");
    wr(TIMER_CONTROL_ADDR, 8'h00);
    wr(COUNT_LOW_ADDR, v[7:0]);
    wr(TIMER_CONTROL_ADDR, 8'h17);
    repeat (160) @(posedge clk_sys);
    chk("tx period", 16'(txPeriod), baud_period(v));
    $display("test baud done");
    tally_and_finish();
  end
endmodule : test_capture_reload_timer
